// File: hdl/fspac_regs.vh
// Constants for the flash protection and identification controller
`ifndef FSPAC_REGS_VH
`define FSPAC_REGS_VH
// ==========================================================
// Operation codes on the user command port
`define FSPAC_OP_READ        3'h0
`define FSPAC_OP_WRITE       3'h1
`define FSPAC_OP_ID_HV       3'h2
`define FSPAC_OP_VERIFY_HV   3'h3
`define FSPAC_OP_ID_CMD      3'h4
`define FSPAC_OP_PROG        3'h5
`define FSPAC_OP_TEMP_UNPROT 3'h6
`define FSPAC_OP_RESET       3'h7
// ==========================================================
// Address fields
`define FSPAC_ADDR_W         22
`define FSPAC_SECT_LSB       16
`define FSPAC_ADDR_A0        0
`define FSPAC_ADDR_A1        1
`define FSPAC_ADDR_A6        6
// ==========================================================
// Command interface values
`define FSPAC_UNLOCK_ADDR1   22'h000555
`define FSPAC_UNLOCK_ADDR2   22'h0002aa
`define FSPAC_UNLOCK_DATA1   8'haa
`define FSPAC_UNLOCK_DATA2   8'h55
`define FSPAC_AUTOSEL_DATA   8'h90
`define FSPAC_PROGRAM_DATA   8'ha0
`define FSPAC_RESET_DATA     8'hf0
// ==========================================================
// Bus timing, in ns, at a 40 ns clock
`define FSPAC_CLK_NS         40
`define FSPAC_PULSE_NS       80
`define FSPAC_SETUP_NS       40
`define FSPAC_RESET_LOW_NS   500
`endif

// File: hdl/fspac_timer.v
// Down counter that times one phase of a bus cycle
`timescale 1ns/1ps
`default_nettype none
module fspac_timer #(
    parameter W = 8                          // Counter width
) (
    input  wire         i_clk,               // System clock
    input  wire         i_rst,               // Async reset, high
    input  wire         i_load,              // Start a new phase
    input  wire [W-1:0] i_count,             // Cycles in the phase
    output reg          o_done               // Phase finished level
);
    reg [W-1:0] cnt;                         // Remaining cycles

    // ==========================================================
    // Count down after a load, flag at zero
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt    <= {W{1'b0}};
            o_done <= 1'b1;
        end else if (i_load) begin
            cnt    <= i_count;
            o_done <= 1'b0;
        end else if (cnt != {W{1'b0}}) begin
            cnt    <= cnt - {{(W-1){1'b0}}, 1'b1};
            o_done <= (cnt == {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule
`default_nettype wire

// File: hdl/fspac_ctrl.v
// Host controller: identification, protection checks and writes to parallel flash
`timescale 1ns/1ps
`default_nettype none
`include "fspac_regs.vh"
module fspac_ctrl #(
    parameter PULSE_CYC = (`FSPAC_PULSE_NS + `FSPAC_CLK_NS - 1) / `FSPAC_CLK_NS,       // Strobe width
    parameter SETUP_CYC = (`FSPAC_SETUP_NS + `FSPAC_CLK_NS - 1) / `FSPAC_CLK_NS,       // Setup/hold
    parameter RST_CYC   = (`FSPAC_RESET_LOW_NS + `FSPAC_CLK_NS - 1) / `FSPAC_CLK_NS    // Reset low
) (
    input  wire        I_CLK_SYS,            // 25 MHz clock
    input  wire        I_RST,                // Async reset, high
    input  wire        i_req,                // Request pulse
    input  wire [2:0]  i_op,                 // Operation code
    input  wire [21:0] i_addr,               // Address or sector select
    input  wire [7:0]  i_wdata,              // Write data
    output reg         o_busy,               // Request in progress
    output reg         o_done,               // Completion pulse
    output reg  [7:0]  o_rdata,              // Read or identification result
    output reg         o_protected,          // Bit 0 of the last read; sector protect status after a verify
    output reg         o_refused,            // Write refused in lockout
    input  wire        i_supply_low,         // Supply below lockout threshold
    output reg  [21:0] o_flash_addr,         // Flash address pins
    input  wire [7:0]  i_data_io,            // Data pins in
    output reg  [7:0]  o_data_io,            // Data pins out
    output reg         o_data_io_oe_n,       // Low while driving data
    output reg         o_chip_sel_n,         // Chip select, low active
    output reg         o_out_en_n,           // Output enable, low active
    output reg         o_write_n,            // Write strobe, low active
    output reg         o_reset_n,            // Flash reset, low active
    output reg         o_hv_addr_bit_nine,   // High voltage on A9 pin
    output reg         o_hv_out_en,          // High voltage on OE pin, never raised
    output reg         o_hv_reset            // High voltage on reset pin
);
    // ==========================================================
    // States, one-hot
    localparam [6:0] S_IDLE  = 7'h01;        // Waiting for request
    localparam [6:0] S_SETUP = 7'h02;        // Address/data setup
    localparam [6:0] S_WSTRB = 7'h04;        // Write strobe low
    localparam [6:0] S_RSTRB = 7'h08;        // Read strobe low
    localparam [6:0] S_HOLD  = 7'h10;        // Strobes released
    localparam [6:0] S_RST   = 7'h20;        // Reset pulse low
    localparam [6:0] S_DONE  = 7'h40;        // Report result

    reg  [6:0]  state;                       // Current state
    reg  [2:0]  op;                          // Latched operation
    reg  [21:0] addr;                        // Latched address
    reg  [7:0]  wdata;                       // Latched data
    reg  [1:0]  step;                        // Cycle index in a sequence
    reg         temp_on;                     // Temporary unprotect held
    reg         sup_m;                       // Lockout sync stage 1
    reg         sup_s;                       // Lockout sync stage 2
    reg  [7:0]  din_m;                       // Data sync stage 1
    reg  [7:0]  din_s;                       // Data sync stage 2
    reg         t_load;                      // Timer load pulse
    reg  [7:0]  t_count;                     // Timer load value
    wire        t_done;                      // Timer finished

    fspac_timer #(.W(8)) u_timer (
        .i_clk   (I_CLK_SYS),
        .i_rst   (I_RST),
        .i_load  (t_load),
        .i_count (t_count),
        .o_done  (t_done)
    );

    // ==========================================================
    // Address of one cycle in a sequence
    function [21:0] seq_addr;
        input [2:0]  f_op;
        input [1:0]  f_step;
        input [21:0] f_addr;
        begin
            case (f_op)
                `FSPAC_OP_ID_HV:
                    seq_addr = {16'h0000, 6'h00} | (f_addr & 22'h000001);
                `FSPAC_OP_VERIFY_HV:
                    seq_addr = {f_addr[21:16], 16'h0002};
                `FSPAC_OP_ID_CMD, `FSPAC_OP_PROG:
                    if (f_step == 2'd0)
                        seq_addr = `FSPAC_UNLOCK_ADDR1;
                    else if (f_step == 2'd1)
                        seq_addr = `FSPAC_UNLOCK_ADDR2;
                    else if (f_step == 2'd2)
                        seq_addr = `FSPAC_UNLOCK_ADDR1;
                    else if (f_op == `FSPAC_OP_ID_CMD)
                        seq_addr = f_addr & 22'h000003;
                    else
                        seq_addr = f_addr;
                default:
                    seq_addr = f_addr;
            endcase
        end
    endfunction

    // ==========================================================
    // Data of one write cycle in a sequence
    function [7:0] seq_data;
        input [2:0] f_op;
        input [1:0] f_step;
        input [7:0] f_data;
        begin
            if (f_op == `FSPAC_OP_WRITE)
                seq_data = f_data;
            else if (f_step == 2'd0)
                seq_data = `FSPAC_UNLOCK_DATA1;
            else if (f_step == 2'd1)
                seq_data = `FSPAC_UNLOCK_DATA2;
            else if (f_step == 2'd2)
                seq_data = (f_op == `FSPAC_OP_ID_CMD) ? `FSPAC_AUTOSEL_DATA : `FSPAC_PROGRAM_DATA;
            else
                seq_data = f_data;
        end
    endfunction

    // ==========================================================
    // Read cycles: plain and high-voltage reads, and the last cycle of command identification
    function is_read_step;
        input [2:0] f_op;
        input [1:0] f_step;
        begin
            is_read_step = (f_op == `FSPAC_OP_READ) || (f_op == `FSPAC_OP_ID_HV) ||
                           (f_op == `FSPAC_OP_VERIFY_HV) ||
                           ((f_op == `FSPAC_OP_ID_CMD) && (f_step == 2'd3));
        end
    endfunction

    // ==========================================================
    // Two-stage synchronisers for supply lockout and data pins
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            sup_m <= 1'b1;
            sup_s <= 1'b1;
            din_m <= 8'h00;
            din_s <= 8'h00;
        end else begin
            sup_m <= i_supply_low;
            sup_s <= sup_m;
            din_m <= i_data_io;
            din_s <= din_m;
        end
    end

    // ==========================================================
    // Main sequencer
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            state              <= S_IDLE;
            op                 <= `FSPAC_OP_READ;
            addr               <= 22'h000000;
            wdata              <= 8'h00;
            step               <= 2'd0;
            temp_on            <= 1'b0;
            t_load             <= 1'b0;
            t_count            <= 8'h00;
            o_busy             <= 1'b0;
            o_done             <= 1'b0;
            o_rdata            <= 8'h00;
            o_protected        <= 1'b0;
            o_refused          <= 1'b0;
            o_flash_addr       <= 22'h000000;
            o_data_io          <= 8'h00;
            o_data_io_oe_n     <= 1'b1;
            o_chip_sel_n       <= 1'b1;      // Inhibit state
            o_out_en_n         <= 1'b1;
            o_write_n          <= 1'b1;
            o_reset_n          <= 1'b1;
            o_hv_addr_bit_nine <= 1'b0;
            o_hv_out_en        <= 1'b0;
            o_hv_reset         <= 1'b0;
        end else begin
            t_load    <= 1'b0;
            o_done    <= 1'b0;
            o_refused <= 1'b0;
            o_hv_reset <= temp_on;
            case (state)
                S_IDLE: begin
                    if (i_req) begin
                        op    <= i_op;
                        addr  <= i_addr;
                        wdata <= i_wdata;
                        step  <= 2'd0;
                        if (i_op == `FSPAC_OP_TEMP_UNPROT) begin
                            // Level only; no unprotect write cycles are issued
                            temp_on <= i_wdata[0];
                            state   <= S_DONE;
                        end else if (i_op == `FSPAC_OP_RESET) begin
                            o_reset_n <= 1'b0;
                            t_count   <= RST_CYC[7:0];
                            t_load    <= 1'b1;
                            o_busy    <= 1'b1;
                            state     <= S_RST;
                        end else if (sup_s && !is_read_step(i_op, 2'd0)) begin
                            o_refused <= 1'b1;
                            o_done    <= 1'b1;
                        end else begin
                            o_busy             <= 1'b1;
                            o_hv_addr_bit_nine <= (i_op == `FSPAC_OP_ID_HV) ||
                                                  (i_op == `FSPAC_OP_VERIFY_HV);
                            t_count            <= SETUP_CYC[7:0];
                            t_load             <= 1'b1;
                            state              <= S_SETUP;
                        end
                    end
                end
                S_SETUP: begin
                    o_flash_addr <= seq_addr(op, step, addr);
                    if (t_done && !t_load) begin
                        o_chip_sel_n <= 1'b0;
                        t_count      <= PULSE_CYC[7:0];
                        t_load       <= 1'b1;
                        if (is_read_step(op, step)) begin
                            o_out_en_n <= 1'b0;
                            state      <= S_RSTRB;
                        end else begin
                            o_data_io      <= seq_data(op, step, wdata);
                            o_data_io_oe_n <= 1'b0;
                            o_out_en_n     <= 1'b1;
                            o_write_n      <= 1'b0;
                            state          <= S_WSTRB;
                        end
                    end
                end
                S_WSTRB, S_RSTRB: begin
                    if (t_done && !t_load) begin
                        if (state == S_RSTRB) begin
                            o_rdata     <= din_s;
                            o_protected <= din_s[0];
                        end
                        o_chip_sel_n <= 1'b1;
                        o_out_en_n   <= 1'b1;
                        o_write_n    <= 1'b1;
                        t_count      <= SETUP_CYC[7:0];
                        t_load       <= 1'b1;
                        state        <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (t_done && !t_load) begin
                        o_data_io_oe_n <= 1'b1;
                        if (((op == `FSPAC_OP_ID_CMD) || (op == `FSPAC_OP_PROG)) && step != 2'd3) begin
                            step    <= step + 2'd1;
                            t_count <= SETUP_CYC[7:0];
                            t_load  <= 1'b1;
                            state   <= S_SETUP;
                        end else begin
                            o_hv_addr_bit_nine <= 1'b0;
                            state              <= S_DONE;
                        end
                    end
                end
                S_RST: begin
                    if (t_done && !t_load) begin
                        o_reset_n <= 1'b1;
                        state     <= S_DONE;
                    end
                end
                S_DONE: begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    state  <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: verification/fspac_ctrl_assertions.sv
// Checker on the pins of the flash protection controller
`timescale 1ns/1ps
`default_nettype none
module fspac_ctrl_checker (
    input wire logic        I_CLK_SYS,          // Clock
    input wire logic        I_RST,              // Reset
    input wire logic        i_supply_low,       // Lockout level
    input wire logic        o_done,             // Completion
    input wire logic        o_refused,          // Refusal
    input wire logic        o_busy,             // Busy
    input wire logic [21:0] o_flash_addr,       // Address pins
    input wire logic        o_data_io_oe_n,     // Data drive
    input wire logic        o_chip_sel_n,       // Chip select
    input wire logic        o_out_en_n,         // Output enable
    input wire logic        o_write_n,          // Write strobe
    input wire logic        o_reset_n,          // Flash reset
    input wire logic        o_hv_addr_bit_nine, // High voltage on nine
    input wire logic        o_hv_out_en,        // High voltage on OE
    input wire logic        o_hv_reset          // High voltage on reset
);
    // ==========================================================
    // Pin relations
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    a_idle_inhibit: assert property (!o_busy && !o_done |-> o_chip_sel_n && o_write_n && o_out_en_n)
        else $error("strobe active while idle");
    a_write_cond: assert property (!o_write_n |-> !o_chip_sel_n && o_out_en_n)
        else $error("write strobe without select or with output enable");
    a_bus_drive: assert property (!o_data_io_oe_n |-> o_out_en_n)
        else $error("data driven while flash outputs enabled");
    a_strobe_width: assert property ($fell(o_write_n) |-> !o_write_n [*2])
        else $error("write pulse too short");
    a_reset_width: assert property ($fell(o_reset_n) |-> !o_reset_n [*8])
        else $error("flash reset pulse too short");
    a_lockout_quiet: assert property (i_supply_low [*3] |-> o_write_n)
        else $error("write strobe during lockout");
    a_refused_done: assert property (o_refused |-> o_done && o_write_n && !$rose(o_busy))
        else $error("refusal without completion");
    a_hv_id_addr: assert property (o_hv_addr_bit_nine && !o_out_en_n |-> !o_flash_addr[6] && o_write_n)
        else $error("identification read with bit six high");
    a_hv_oe_off: assert property (!o_hv_out_en)
        else $error("high voltage on output enable");
    cover property (o_refused);
    cover property ($rose(o_hv_reset));
    cover property (o_hv_addr_bit_nine && !o_out_en_n);
endmodule
bind fspac_ctrl fspac_ctrl_checker chk_u (.I_CLK_SYS, .I_RST, .i_supply_low, .o_done, .o_refused, .o_busy,
    .o_flash_addr, .o_data_io_oe_n, .o_chip_sel_n, .o_out_en_n, .o_write_n, .o_reset_n, .o_hv_addr_bit_nine,
    .o_hv_out_en, .o_hv_reset);
`default_nettype wire

// File: verification/fspac_flash_model.sv
// Behavioural model of the parallel flash device
`timescale 1ns/1ps
`default_nettype none
module fspac_flash_model #(
    parameter logic [7:0] MAKER_CODE  = 8'h5a,  // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hc3   // Arbitrary value
) (
    input  wire logic [21:0] i_addr,            // Address pins
    input  wire logic [7:0]  i_data,            // Data pins in
    input  wire logic        i_chip_sel_n,      // Chip select
    input  wire logic        i_out_en_n,        // Output enable
    input  wire logic        i_write_n,         // Write strobe
    input  wire logic        i_reset_n,         // Reset pin
    input  wire logic        i_hv_a9,           // High voltage on nine
    input  wire logic        i_hv_reset,        // High voltage on reset
    input  wire logic        i_supply_low,      // Supply below lockout
    output logic      [7:0]  o_data             // Data pins out
);
    logic [17:0] prot = '0;                     // Block protection
    logic [1:0]  step = 2'h0;                   // Unlock progress
    logic        autosel = 1'b0;                // Identification mode
    logic        progm = 1'b0;                  // Program armed
    logic        sel = 1'b0;                    // Write qualified at fall
    logic [21:0] la, pa = '1;                   // Latched and last address
    logic [7:0]  pd = 8'hff, rd, held = 8'h00;  // Stored, read and last data
    // Sector number to protection block
    function automatic logic [4:0] blk(input logic [5:0] s);
        if (s == 6'h00) return 5'h00;
        if (s < 6'h04) return 5'h01;
        if (s < 6'h3c) return {1'b0, s[5:2]} + 5'h01;
        if (s < 6'h3f) return 5'h10;
        return 5'h11;
    endfunction
    // Address latched at falling strobe
    always @(negedge i_write_n) begin
        la = i_addr;
        sel = !i_chip_sel_n && i_out_en_n;
    end
    // Command interface on rising strobe
    always @(posedge i_write_n or negedge i_reset_n) begin
        if (!i_reset_n || i_supply_low) begin
            step <= 2'h0;
            autosel <= 1'b0;
            progm <= 1'b0;
        end else if (sel) begin
            if (progm) begin
                if (!prot[blk(la[21:16])] || i_hv_reset) begin
                    pa <= la;
                    pd <= i_data;
                end
                progm <= 1'b0;
            end else if (step == 2'h0 && la == 22'h555 && i_data == 8'haa) step <= 2'h1;
            else if (step == 2'h1 && la == 22'h2aa && i_data == 8'h55) step <= 2'h2;
            else if (step == 2'h2 && la == 22'h555 && i_data == 8'h90) begin
                autosel <= 1'b1;
                step <= 2'h0;
            end else if (step == 2'h2 && la == 22'h555 && i_data == 8'ha0) begin
                progm <= 1'b1;
                autosel <= 1'b0;
                step <= 2'h0;
            end else begin
                step <= 2'h0;
                autosel <= 1'b0;
            end
        end
    end
    // Read data: codes, status or array
    always @* begin
        if (i_hv_a9 || autosel)
            rd = i_addr[1] ? {7'h00, prot[blk(i_addr[21:16])]} : (i_addr[0] ? DEVICE_CODE : MAKER_CODE);
        else
            rd = (i_addr == pa) ? pd : 8'hff;
    end
    // Released bus shows the inverse of the last value
    always @* begin
        if (!i_chip_sel_n && !i_out_en_n && i_reset_n) begin
            held = rd;
            o_data = rd;
        end else
            o_data = ~held;
    end
endmodule
`default_nettype wire

// File: verification/fspac_tb.sv
// Self-checking bench for the flash protection controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic I_CLK_SYS = 1'b0, I_RST = 1'b1, i_req = 1'b0, i_supply_low = 1'b0; // Inputs
    logic [2:0]  i_op = 3'h0;                   // Operation
    logic [21:0] i_addr = '0, fa;               // Address in, pins
    logic [7:0]  i_wdata = 8'h00, rdata, dout, dev; // Data paths
    logic busy, done, prt, refused, doe_n, ce_n, oe_n, we_n, rst_n, hv9, hvoe, hvrst; // Pins
    int miscompares = 0, check_count = 0;       // Counters
    logic [5:0] sect [6] = '{6'h00, 6'h02, 6'h04, 6'h3b, 6'h3e, 6'h3f}; // Sectors
    logic       pexp [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};       // Status after protect
    wire logic [7:0] bus = !doe_n ? dout : dev; // Data wire
    always #20 I_CLK_SYS = ~I_CLK_SYS;
    fspac_ctrl dut_u (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .i_req(i_req), .i_op(i_op), .i_addr(i_addr),
        .i_wdata(i_wdata), .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_protected(prt),
        .o_refused(refused), .i_supply_low(i_supply_low), .o_flash_addr(fa), .i_data_io(bus), .o_data_io(dout),
        .o_data_io_oe_n(doe_n), .o_chip_sel_n(ce_n), .o_out_en_n(oe_n), .o_write_n(we_n), .o_reset_n(rst_n),
        .o_hv_addr_bit_nine(hv9), .o_hv_out_en(hvoe), .o_hv_reset(hvrst));
    fspac_flash_model flash_u (.i_addr(fa), .i_data(bus), .i_chip_sel_n(ce_n), .i_out_en_n(oe_n),
        .i_write_n(we_n), .i_reset_n(rst_n), .i_hv_a9(hv9), .i_hv_reset(hvrst), .i_supply_low(i_supply_low),
        .o_data(dev));
    // ==========================================================
    // Tasks
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic run_op(input logic [2:0] op, input logic [21:0] a, input logic [7:0] d);
        int n;
        @(posedge I_CLK_SYS);
        i_req <= 1'b1;
        i_op <= op;
        i_addr <= a;
        i_wdata <= d;
        @(posedge I_CLK_SYS);
        i_req <= 1'b0;
        n = 0;
        #1;
        while (done !== 1'b1 && n < 400) begin
            @(posedge I_CLK_SYS);
            #1;
            n++;
        end
        chk("done", {7'h00, done}, 8'h01);
        chk("busy", {7'h00, busy}, 8'h00);
    endtask
    task automatic test_done;
        $display("Checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================================
    // Watchdog
    initial begin
        #(40 * 20000);
        miscompares++;
        test_done;
    end
    // ==========================================================
    // Test sequence
    initial begin
        repeat (10) @(posedge I_CLK_SYS);
        I_RST <= 1'b0;
        repeat (3) @(posedge I_CLK_SYS);
        run_op(3'h2, 22'h000000, 8'h00);
        chk("hv maker", rdata, 8'h5a);
        run_op(3'h2, 22'h3fffbd, 8'h00);
        chk("hv device", rdata, 8'hc3);
        run_op(3'h4, 22'h000000, 8'h00);
        chk("cmd maker", rdata, 8'h5a);
        run_op(3'h4, 22'h000001, 8'h00);
        chk("cmd device", rdata, 8'hc3);
        $display("identification test done");
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 6; i++) begin
                run_op(3'h3, {sect[i], 16'h0000}, 8'h00);
                chk("sector status", rdata, {7'h00, p ? pexp[i] : 1'b0});
                chk("protect bit", {7'h00, prt}, {7'h00, p ? pexp[i] : 1'b0});
            end
            flash_u.prot[1] = 1'b1;
            flash_u.prot[16] = 1'b1;
        end
        $display("protection status test done");
        run_op(3'h5, 22'h050010, 8'h3c);
        run_op(3'h0, 22'h050010, 8'h00);
        chk("program open", rdata, 8'h3c);
        run_op(3'h5, 22'h020004, 8'h77);
        run_op(3'h0, 22'h020004, 8'h00);
        chk("program protected", rdata, 8'hff);
        run_op(3'h6, 22'h000000, 8'h01);
        chk("hv reset on", {7'h00, hvrst}, 8'h01);
        run_op(3'h5, 22'h020004, 8'h77);
        run_op(3'h0, 22'h020004, 8'h00);
        chk("temp unprotect", rdata, 8'h77);
        run_op(3'h6, 22'h000000, 8'h00);
        chk("hv reset off", {7'h00, hvrst}, 8'h00);
        run_op(3'h5, 22'h020008, 8'h11);
        run_op(3'h0, 22'h020008, 8'h00);
        chk("protect restored", rdata, 8'hff);
        run_op(3'h3, 22'h020000, 8'h00);
        chk("status kept", rdata, 8'h01);
        $display("program test done");
        i_supply_low <= 1'b1;
        repeat (3) @(posedge I_CLK_SYS);
        run_op(3'h5, 22'h050020, 8'h44);
        chk("refused", {7'h00, refused}, 8'h01);
        i_supply_low <= 1'b0;
        repeat (3) @(posedge I_CLK_SYS);
        run_op(3'h0, 22'h050020, 8'h00);
        chk("lockout no write", rdata, 8'hff);
        run_op(3'h4, 22'h000000, 8'h00);
        run_op(3'h1, 22'h000123, 8'h00);
        run_op(3'h0, 22'h020004, 8'h00);
        chk("bad cycle exits id", rdata, 8'h77);
        run_op(3'h4, 22'h000000, 8'h00);
        run_op(3'h7, 22'h000000, 8'h00);
        run_op(3'h0, 22'h020004, 8'h00);
        chk("read after reset", rdata, 8'h77);
        $display("lockout and reset test done");
        test_done;
    end
endmodule
`default_nettype wire
